// >>> rtl/prescaler_counter.v
`timescale 1ns/10ps

// ==========================================================
// Shared 8-bit prescaler count, hidden from software
module prescaler_counter
(
    input wire hclk,
    input wire hresetn,
    input wire clr,
    input wire inc,
    output reg [7:0] cnt_q
);

    wire [7:0] cnt_d;

    // Clear beats a coincident count so a cleared prescaler starts at zero
    assign cnt_d = clr ? 8'h00 : (inc ? cnt_q + 8'h01 : cnt_q);

    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            cnt_q <= 8'h00;
        end
        else
        begin
            cnt_q <= cnt_d;
        end
    end

endmodule // prescaler_counter

// >>> rtl/timer0_ext_clock_prescaler.v
// How it works
// - Without prescaler, sample the count input on phase two and four.
// - With prescaler, divide input by a counter ahead of the sampler.
// - In counter mode, timer increments only after the sampled level is seen rising.
// - One 8-bit counter serves timer or watchdog, never both.
// - Option bits three to zero pick assignment and ratio.
// - Timer count write clears prescaler while assigned to timer.
// - Watchdog clear resets watchdog and prescaler when assigned there.
// - Prescaler count is not visible to software at all.
// - Timer count write leaves the assignment bit untouched.
// - Assignment may change at any time without stopping anything.
// - Assignment bit clear routes to timer, set routes to watchdog.
// - Timer count write inhibits increments for two instruction cycles.
// - Edge select clear counts rising edges, set counts falling.
// - Overflow from ff to 00 sets a sticky flag until cleared.
`timescale 1ns/10ps
`include "timer0_regs.vh"

module timer0_ext_clock_prescaler
(
    input wire hclk,
    input wire hresetn,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output reg [31:0] hrdata,
    output reg hreadyout,
    output reg hresp,
    input wire ext_count_input_pin,
    input wire wdt_tick,
    output reg wdt_clear_q,
    output reg wdt_timeout_q,
    output reg [7:0] interrupt_control_q,
    output reg [7:0] port_a_direction_q
);

    // ==========================================================
    // Instruction phase ring, one-hot
    localparam [3:0] PH_ONE = 4'h1;
    localparam [3:0] PH_TWO = 4'h2;
    localparam [3:0] PH_THREE = 4'h4;
    localparam [3:0] PH_FOUR = 4'h8;
    localparam [3:0] INHIBIT_LOAD = `INHIBIT_CYC;

    reg [3:0] phase_q;
    reg [3:0] phase_d;
    wire phase_clock_two;
    wire phase_clock_four;

    always @*
    begin
        case (phase_q)
            PH_ONE: phase_d = PH_TWO;
            PH_TWO: phase_d = PH_THREE;
            PH_THREE: phase_d = PH_FOUR;
            PH_FOUR: phase_d = PH_ONE;
            default: phase_d = PH_ONE;
        endcase
    end

    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            phase_q <= PH_ONE;
        end
        else
        begin
            phase_q <= phase_d;
        end
    end

    assign phase_clock_two = (phase_q == PH_TWO);
    assign phase_clock_four = (phase_q == PH_FOUR);

    // ==========================================================
    // Registers
    reg [7:0] timer_count_q;
    reg [7:0] option_config_q;
    wire [2:0] prescale_ratio_field;
    wire prescaler_assign_select;
    wire source_edge_select;
    wire count_source_select;

    assign prescale_ratio_field =
        option_config_q[`OPT_RATIO_MSB:`OPT_RATIO_LSB];
    assign prescaler_assign_select = option_config_q[`OPT_ASSIGN_BIT];
    assign source_edge_select = option_config_q[`OPT_EDGE_BIT];
    assign count_source_select = option_config_q[`OPT_SOURCE_BIT];

    // ==========================================================
    // AHB-Lite slave
    reg wr_pend_q;
    reg rd_pend_q;
    reg [7:0] idx_q;
    reg idx_ok_q;
    wire take;
    wire addr_ok;
    wire wr_timer;
    wire wr_intc;
    wire wr_option;
    wire wr_porta;
    wire wdt_clear_instr;
    reg [7:0] rd_mux;

    // Unaligned or out-of-range addresses read zero and drop writes
    assign addr_ok = (haddr[31:10] == 22'h000000) && (haddr[1:0] == 2'h0);
    assign take = hsel && hready && htrans[`HTRANS_NONSEQ_BIT];

    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_pend_q <= 1'b0;
            rd_pend_q <= 1'b0;
            idx_q <= 8'h00;
            idx_ok_q <= 1'b0;
        end
        else
        begin
            wr_pend_q <= take && hwrite;
            rd_pend_q <= take && !hwrite;
            if (take)
            begin
                idx_q <= haddr[9:2];
                idx_ok_q <= addr_ok;
            end
        end
    end

    assign wr_timer = wr_pend_q && idx_ok_q && (idx_q == `IDX_TIMER_COUNT);
    assign wr_intc = wr_pend_q && idx_ok_q &&
        (idx_q == `IDX_INTERRUPT_CONTROL);
    assign wr_option = wr_pend_q && idx_ok_q && (idx_q == `IDX_OPTION_CONFIG);
    assign wr_porta = wr_pend_q && idx_ok_q &&
        (idx_q == `IDX_PORT_A_DIRECTION);
    assign wdt_clear_instr = wr_pend_q && idx_ok_q &&
        (idx_q == `IDX_WATCHDOG_CLEAR);

    // Prescaler count has no address of its own
    always @*
    begin
        rd_mux = 8'h00;
        if (idx_ok_q)
        begin
            case (idx_q)
                `IDX_TIMER_COUNT: rd_mux = timer_count_q;
                `IDX_INTERRUPT_CONTROL: rd_mux = interrupt_control_q;
                `IDX_OPTION_CONFIG: rd_mux = option_config_q;
                `IDX_PORT_A_DIRECTION: rd_mux = port_a_direction_q;
                default: rd_mux = 8'h00;
            endcase
        end
    end

    // Reads take one wait state so a write just before is seen
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            hreadyout <= 1'b1;
            hrdata <= 32'h00000000;
            hresp <= `HRESP_OKAY;
        end
        else
        begin
            hresp <= `HRESP_OKAY;
            if (take && !hwrite)
            begin
                hreadyout <= 1'b0;
            end
            else if (rd_pend_q)
            begin
                hreadyout <= 1'b1;
                hrdata <= {24'h000000, rd_mux};
            end
        end
    end

    // ==========================================================
    // Count input synchroniser and edge select
    reg pin_meta_q;
    reg pin_sync_q;
    reg ext_prev_q;
    wire ext_lvl;
    wire ext_rise;

    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            pin_meta_q <= 1'b0;
            pin_sync_q <= 1'b0;
            // Reset option inverts the low pin, so idle level is high
            ext_prev_q <= 1'b1;
        end
        else
        begin
            pin_meta_q <= ext_count_input_pin;
            pin_sync_q <= pin_meta_q;
            ext_prev_q <= ext_lvl;
        end
    end

    // Inverted level makes a falling pin edge look rising
    assign ext_lvl = pin_sync_q ^ source_edge_select;
    assign ext_rise = ext_lvl && !ext_prev_q;

    // ==========================================================
    // Shared prescaler
    wire [7:0] pre_cnt;
    wire pre_inc;
    wire pre_clr;

    // Only one consumer feeds the counter at a time
    assign pre_inc = prescaler_assign_select ? wdt_tick :
        (count_source_select ? ext_rise : phase_clock_four);
    assign pre_clr = (wr_timer && !prescaler_assign_select) ||
        (wdt_clear_instr && prescaler_assign_select);

    prescaler_counter u_prescaler
    (
        .hclk(hclk),
        .hresetn(hresetn),
        .clr(pre_clr),
        .inc(pre_inc),
        .cnt_q(pre_cnt)
    );

    // ==========================================================
    // Timer source and phase sampling
    reg samp_q;
    reg samp_prev_q;
    reg pre_prev_q;
    wire pre_out;
    wire src_lvl;
    wire samp_rise;
    wire pre_rise;
    wire timer_tick;

    // Bit n toggles every 2^n counts, so its rise divides by 2^(n+1)
    assign pre_out = pre_cnt[prescale_ratio_field];
    assign src_lvl = prescaler_assign_select ? ext_lvl : pre_out;

    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            // Start at the post-reset level, else a false count follows
            samp_q <= 1'b1;
            samp_prev_q <= 1'b1;
            pre_prev_q <= 1'b0;
        end
        else
        begin
            if (phase_clock_two || phase_clock_four)
            begin
                samp_q <= src_lvl;
            end
            samp_prev_q <= samp_q;
            pre_prev_q <= pre_out;
        end
    end

    assign samp_rise = samp_q && !samp_prev_q;
    assign pre_rise = pre_out && !pre_prev_q;
    assign timer_tick = count_source_select ? samp_rise :
        (prescaler_assign_select ? phase_clock_four : pre_rise);

    // ==========================================================
    // Timer count, write inhibit and overflow
    reg [3:0] inhibit_q;
    wire inc_ok;
    wire overflow;

    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            inhibit_q <= 4'h0;
        end
        else if (wr_timer)
        begin
            inhibit_q <= INHIBIT_LOAD;
        end
        else if (inhibit_q != 4'h0)
        begin
            inhibit_q <= inhibit_q - 4'h1;
        end
    end

    assign inc_ok = timer_tick && (inhibit_q == 4'h0) && !wr_timer;
    assign overflow = inc_ok && (timer_count_q == 8'hff);

    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            timer_count_q <= `RST_TIMER_COUNT;
        end
        else if (wr_timer)
        begin
            timer_count_q <= hwdata[7:0];
        end
        else if (inc_ok)
        begin
            timer_count_q <= timer_count_q + 8'h01;
        end
    end

    // Overflow set wins over a software clear in the same cycle
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            interrupt_control_q <= `RST_INTERRUPT_CONTROL;
        end
        else if (wr_intc)
        begin
            interrupt_control_q <= hwdata[7:0];
            if (overflow)
            begin
                interrupt_control_q[`INTC_OVF_FLAG_BIT] <= 1'b1;
            end
        end
        else if (overflow)
        begin
            interrupt_control_q[`INTC_OVF_FLAG_BIT] <= 1'b1;
        end
    end

    // Option changes apply at once, nothing is halted
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            option_config_q <= `RST_OPTION_CONFIG;
            port_a_direction_q <= `RST_PORT_A_DIRECTION;
        end
        else
        begin
            if (wr_option)
            begin
                option_config_q <= hwdata[7:0];
            end
            if (wr_porta)
            begin
                port_a_direction_q <= hwdata[7:0] & `MASK_PORT_A_DIRECTION;
            end
        end
    end

    // ==========================================================
    // Watchdog postscaler
    reg wdt_prev_q;
    wire [2:0] wdt_bit;
    wire wdt_out;
    wire wdt_rise;
    wire wdt_fire;

    // Ratio n>0 divides by 2^n; the timer side then runs undivided
    assign wdt_bit = prescale_ratio_field - 3'h1;
    assign wdt_out = pre_cnt[wdt_bit];
    assign wdt_rise = wdt_out && !wdt_prev_q;
    assign wdt_fire = (!prescaler_assign_select ||
        (prescale_ratio_field == 3'h0)) ? wdt_tick : wdt_rise;

    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wdt_prev_q <= 1'b0;
            wdt_clear_q <= 1'b0;
            wdt_timeout_q <= 1'b0;
        end
        else
        begin
            wdt_prev_q <= wdt_out;
            wdt_clear_q <= wdt_clear_instr;
            wdt_timeout_q <= wdt_fire && !wdt_clear_instr;
        end
    end

endmodule // timer0_ext_clock_prescaler

// >>> rtl/timer0_regs.vh
`ifndef TIMER0_REGS_VH
`define TIMER0_REGS_VH

// ==========================================================
// Register indices (byte address = index * 4)
`define IDX_TIMER_COUNT 8'h01
`define IDX_INTERRUPT_CONTROL 8'h0b
`define IDX_OPTION_CONFIG 8'h81
`define IDX_PORT_A_DIRECTION 8'h85
`define IDX_WATCHDOG_CLEAR 8'h04

// ==========================================================
// Reset values
`define RST_TIMER_COUNT 8'h00
`define RST_INTERRUPT_CONTROL 8'h00
`define RST_OPTION_CONFIG 8'hff
`define RST_PORT_A_DIRECTION 8'h3f
`define MASK_PORT_A_DIRECTION 8'h3f

// ==========================================================
// Field positions
`define OPT_RATIO_LSB 0
`define OPT_RATIO_MSB 2
`define OPT_ASSIGN_BIT 3
`define OPT_EDGE_BIT 4
`define OPT_SOURCE_BIT 5
`define INTC_OVF_FLAG_BIT 2

// ==========================================================
// Timing
`define PHASES_PER_INSTR 4'h4
`define INHIBIT_INSTR 4'h2
`define INHIBIT_CYC (`PHASES_PER_INSTR * `INHIBIT_INSTR)

// ==========================================================
// AHB encodings
`define HTRANS_NONSEQ_BIT 1
`define HRESP_OKAY 1'b0

`endif

// >>> verification/count_source.sv
`timescale 1ns/10ps
// ==========================================================
// External count source, idle low between bursts
module count_source
(
    input wire hclk,
    output logic pin
);
    initial pin = 1'b0;
    // Each level held for at least two sample phases
    task burst(input int n, input int h);
        repeat (n)
        begin
            repeat (h) @(posedge hclk);
            pin <= 1'b1;
            repeat (h) @(posedge hclk);
            pin <= 1'b0;
        end
    endtask
    task set(input logic b);
        @(posedge hclk);
        pin <= b;
    endtask
endmodule // count_source

// >>> verification/timer0_checker.sv
`timescale 1ns/10ps
// ==========================================================
// Bus, flag and watchdog pulse checks
module timer0_checker
(
    input wire hclk,
    input wire hresetn,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    input wire [31:0] hrdata,
    input wire hreadyout,
    input wire hresp,
    input wire ext_count_input_pin,
    input wire wdt_tick,
    input wire wdt_clear_q,
    input wire wdt_timeout_q,
    input wire [7:0] interrupt_control_q,
    input wire [7:0] port_a_direction_q
);
    reg wr_q;
    reg rd_q;
    reg [31:0] a_q;
    reg [7:0] opt_q;
    wire take = hsel && hready && htrans[1];
    wire rdone = rd_q && hreadyout;
    // Read data phase lasts until hreadyout returns
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_q <= 1'b0;
            rd_q <= 1'b0;
            a_q <= 32'h0;
            opt_q <= 8'hff;
        end
        else
        begin
            wr_q <= take && hwrite;
            rd_q <= take ? !hwrite : (rd_q && !hreadyout);
            a_q <= take ? haddr : a_q;
            opt_q <= (wr_q && a_q == 32'h204) ? hwdata[7:0] : opt_q;
        end
    end
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    chk_clear_pulse: assert property (
        wdt_clear_q == $past(wr_q && a_q == 32'h10))
        else $error("watchdog clear pulse mismatch");
    chk_timeout_tick: assert property (
        wdt_timeout_q |->
        (($past(opt_q[3]) && $past(opt_q[2:0]) != 3'h0) ?
        $past(wdt_tick, 2) : $past(wdt_tick)))
        else $error("timeout without tick");
    chk_opt_read: assert property (
        rdone && a_q == 32'h204 |-> hrdata == {24'h0, opt_q})
        else $error("option readback wrong");
    chk_count_hidden: assert property (
        rdone && !(a_q inside {32'h4, 32'h2c, 32'h204, 32'h214})
        |-> hrdata == 32'h0)
        else $error("unmapped read not zero");
    chk_flag_sticky: assert property (
        $fell(interrupt_control_q[2]) |-> $past(wr_q && a_q == 32'h2c))
        else $error("overflow flag dropped alone");
    chk_ic_write: assert property (
        wr_q && a_q == 32'h2c |=> interrupt_control_q[1:0] ==
        $past(hwdata[1:0]) && interrupt_control_q[7:3] == $past(hwdata[7:3]))
        else $error("control write lost");
    chk_read_wait: assert property (
        take && !hwrite |=> !hreadyout ##1 hreadyout)
        else $error("read wait state wrong");
    chk_dir_write: assert property (
        wr_q && a_q == 32'h214 |=>
        port_a_direction_q == ($past(hwdata[7:0]) & 8'h3f))
        else $error("direction write wrong");
    chk_resp_okay: assert property (!hresp)
        else $error("response not okay");
endmodule // timer0_checker

bind timer0_ext_clock_prescaler timer0_checker timer0_checker_inst (.hclk,
    .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
    .hrdata, .hreadyout, .hresp, .ext_count_input_pin, .wdt_tick,
    .wdt_clear_q, .wdt_timeout_q, .interrupt_control_q, .port_a_direction_q);

// >>> verification/timer0_ext_clock_prescaler_tb.sv
`timescale 1ns/10ps
// ==========================================================
// Bench top
module timer0_ext_clock_prescaler_tb;
    localparam logic [31:0] TMR = 32'h04;
    localparam logic [31:0] IC = 32'h2c;
    localparam logic [31:0] OPT = 32'h204;
    localparam logic [31:0] DIR = 32'h214;
    localparam logic [31:0] WCLR = 32'h10;
    logic hclk, hresetn, hsel, hwrite, tick;
    logic [31:0] haddr, hwdata, v, d;
    logic [1:0] htrans;
    wire [31:0] hrdata;
    wire hreadyout, hresp, pin, wclr, wto;
    wire [7:0] ic, dir;
    int bad_count, num_checks, cyc, to_cnt, h;
    logic [31:0] ra [6] = '{OPT, DIR, IC, TMR, WCLR, 32'h300};
    logic [7:0] rv [6] = '{8'hff, 8'h3f, 8'h00, 8'h00, 8'h00, 8'h00};
    timer0_ext_clock_prescaler timer0_ext_clock_prescaler_inst (.hclk,
        .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
        .hready(hreadyout), .hrdata, .hreadyout, .hresp,
        .ext_count_input_pin(pin), .wdt_tick(tick), .wdt_clear_q(wclr),
        .wdt_timeout_q(wto), .interrupt_control_q(ic),
        .port_a_direction_q(dir));
    count_source count_source_inst (.hclk, .pin);
    initial
    begin
        hclk = 1'b0;
        forever #2 hclk = ~hclk;
    end
    // ==========================================================
    // Run limit and watchdog model
    always @(posedge hclk)
    begin
        cyc++;
        to_cnt += (wto === 1'b1);
        if (cyc > 40000)
        begin
            bad_count++;
            close_out();
        end
    end
    task close_out;
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task check(input logic [31:0] s, input logic [31:0] e);
        num_checks++;
        if (s !== e)
        begin
            bad_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, s, e);
        end
    endtask
    // ==========================================================
    // Bus master, waits on hready only
    task bus(input logic w, input logic [31:0] a, input logic [7:0] b);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= a;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= {24'h0, b};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        v = hrdata;
    endtask
    task wr(input logic [31:0] a, input logic [7:0] b);
        bus(1'b1, a, b);
    endtask
    task rd(input logic [31:0] a, input logic [7:0] e);
        bus(1'b0, a, 8'h0);
        check(v, {24'h0, e});
    endtask
    task ticks(input int n);
        repeat (n)
        begin
            tick <= 1'b1;
            @(posedge hclk);
            tick <= 1'b0;
            repeat (3) @(posedge hclk);
        end
    endtask
    task count_run(input logic [7:0] o, input int n, input logic [7:0] e);
        wr(OPT, o);
        repeat (10) @(posedge hclk);
        wr(TMR, 8'h0);
        repeat (10) @(posedge hclk);
        count_source_inst.burst(n, h);
        repeat (20) @(posedge hclk);
        rd(TMR, e);
    endtask
    initial
    begin
        {hresetn, hsel, haddr, htrans, hwrite, hwdata, tick} = '0;
        void'($urandom(32'h49e8));
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        for (int i = 0; i < 6; i++)
            rd(ra[i], rv[i]);
        d = $urandom;
        wr(DIR, d[7:0]);
        rd(DIR, d[7:0] & 8'h3f);
        $display("registers done");
        // Ratio sweep, count window allows for phase of the ring
        for (int r = 0; r < 8; r++)
        begin
            wr(OPT, r[7:0]);
            wr(TMR, 8'h0);
            repeat (32 << r) @(posedge hclk);
            bus(1'b0, TMR, 8'h0);
            check(v >= 3 && v <= 4, 1);
        end
        wr(OPT, 8'h08);
        wr(TMR, 8'h0);
        repeat (40) @(posedge hclk);
        bus(1'b0, TMR, 8'h0);
        check(v >= 7 && v <= 9, 1);
        wr(TMR, 8'hfe);
        rd(TMR, 8'hfe);
        repeat (64) @(posedge hclk);
        check(ic[2], 1'b1);
        wr(IC, 8'h20);
        @(posedge hclk);
        check(ic, 8'h20);
        $display("timer mode done");
        for (int e = 0; e < 2; e++)
        begin
            h = 4 + $urandom % 6;
            count_run(8'h28 | {e[3:0], 4'h0}, 5, 8'h5);
            count_source_inst.set(1'b1);
            repeat (20) @(posedge hclk);
            rd(TMR, 8'h6 - e[7:0]);
            count_source_inst.set(1'b0);
        end
        count_run(8'h21, 8, 8'h2);
        count_source_inst.burst(3, h);
        count_run(8'h21, 2, 8'h1);
        rd(OPT, 8'h21);
        // Falling edges into the prescaler, pin held high for the last read
        count_run(8'h30, 2, 8'h1);
        count_source_inst.set(1'b1);
        repeat (20) @(posedge hclk);
        rd(TMR, 8'h1);
        count_source_inst.set(1'b0);
        $display("counter mode done");
        wr(TMR, 8'h0);
        wr(OPT, 8'h0a);
        wr(WCLR, 8'h0);
        to_cnt = 0;
        ticks(12);
        check(to_cnt, 3);
        ticks(2);
        wr(WCLR, 8'h0);
        to_cnt = 0;
        // Postscaler bit rises at half the ratio after a clear
        ticks(1);
        check(to_cnt, 0);
        ticks(1);
        check(to_cnt, 1);
        wr(WCLR, 8'h0);
        wr(OPT, 8'h02);
        to_cnt = 0;
        ticks(3);
        check(to_cnt, 3);
        $display("watchdog done");
        close_out();
    end
endmodule // timer0_ext_clock_prescaler_tb
